// ==== ddr_timing_priority_perfcount.sv ====
// timing second set, addressing, priority raise and performance counters
// Contract
// - timing register writable only while unlocked
// - row open limit is field plus one
// - power-down exit wait before non-read commands
// - termination delay field is storage only
// - self-refresh exit wait before non-read commands
// - self-refresh exit wait before read commands
// - last read to precharge spacing
// - spacing between clock-enable pin transitions
// - second configuration used only with special addressing
// - writing second configuration starts initialization
// - partial-array field decodes bank coverage
// - row-size code n gives nine plus n
// - raise oldest command after set transfers
// - raise count value N means N+1
// - open rows first on bank conflict
// - count zero follows strict master priority
// - two read-only counters reset to zero
// - counters clear only by module reset
// - filter 3h counts received write bursts
// - filter 9h counts fifo-not-empty memory cycles
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module ddr_timing_priority_perfcount (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // memory clock from the link
  input wire logic i_mem_clk,
  // events from the controller core
  input wire logic i_pd_exit,
  input wire logic i_sr_exit,
  input wire logic i_rd_cmd,
  input wire logic i_act_cmd,
  input wire logic i_pre_cmd,
  input wire logic i_cke_toggle,
  input wire logic i_refresh_tick,
  input wire logic i_xfer,
  input wire logic i_rd_rx,
  input wire logic i_wr_rx,
  input wire logic i_fifo_full,
  input wire logic i_fifo_nonempty,
  // permissions and settings to the core
  output logic o_nonread_ok,
  output logic o_read_ok,
  output logic o_pre_ok,
  output logic o_cke_ok,
  output logic o_row_close_req,
  output logic o_raise_oldest,
  output logic o_open_row_first,
  output logic o_init_start,
  output logic [4:0] o_row_bits,
  output logic [2:0] o_partial_array_refresh_select_code
);

  // ==========================================================
  // register state
  logic [31:0] cfg;
  logic [30:0] tim2;
  logic [2:0] partial_array_refresh_select;
  logic [2:0] rowsize;
  logic [7:0] prio;
  logic [31:0] filt;
  logic [31:0] pc [2];

  // decoded strobes
  logic wr_cfg;
  logic wr_tim2;
  logic wr_cfg2;
  logic wr_prio;
  logic wr_filt;
  assign wr_cfg = i_wr && (i_addr == ddr_tpp_pkg::OFF_CFG);
  assign wr_tim2 = i_wr && (i_addr == ddr_tpp_pkg::OFF_TIM2);
  assign wr_cfg2 = i_wr && (i_addr == ddr_tpp_pkg::OFF_CFG2);
  assign wr_prio = i_wr && (i_addr == ddr_tpp_pkg::OFF_PRIO);
  assign wr_filt = i_wr && (i_addr == ddr_tpp_pkg::OFF_FILT);

  // timing fields
  logic [3:0] rasmax;
  logic [1:0] t_xp;
  logic [6:0] t_xsnr;
  logic [7:0] t_xsrd;
  logic [2:0] t_rtp;
  logic [4:0] t_cke;
  logic unlock;
  assign rasmax = tim2[ddr_tpp_pkg::T2_RASMAX_LO +: 4];
  assign t_xp = tim2[ddr_tpp_pkg::T2_XP_LO +: 2];
  assign t_xsnr = tim2[ddr_tpp_pkg::T2_XSNR_LO +: 7];
  assign t_xsrd = tim2[ddr_tpp_pkg::T2_XSRD_LO +: 8];
  assign t_rtp = tim2[ddr_tpp_pkg::T2_RTP_LO +: 3];
  assign t_cke = tim2[ddr_tpp_pkg::T2_CKE_LO +: 5];
  assign unlock = cfg[ddr_tpp_pkg::CFG_UNLOCK];

  // ==========================================================
  // main configuration register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cfg <= 32'h00000000;
    end else if (wr_cfg) begin
      cfg <= i_wdata;
    end
  end

  // second timing register, held while locked
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tim2 <= ddr_tpp_pkg::T2_RESET;
    end else if (wr_tim2 && unlock) begin
      tim2 <= i_wdata[30:0]; // termination delay kept only
    end
  end // locked writes dropped

  // second configuration register and init kick
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      partial_array_refresh_select <= 3'h0;
      rowsize <= 3'h0;
      o_init_start <= 1'b0;
    end else begin
      o_init_start <= wr_cfg2;
      if (wr_cfg2) begin
        partial_array_refresh_select <= i_wdata[ddr_tpp_pkg::C2_PARTIAL_ARRAY_REFRESH_SELECT_LO +: 3];
        rowsize <= i_wdata[ddr_tpp_pkg::C2_ROW_LO +: 3];
      end
    end
  end

  // priority raise and filter registers
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prio <= ddr_tpp_pkg::PRIO_RESET;
      filt <= ddr_tpp_pkg::FILT_RESET;
    end else begin
      if (wr_prio) begin
        prio <= i_wdata[7:0];
      end
      if (wr_filt) begin
        filt <= i_wdata;
      end
    end
  end

  // ==========================================================
  // addressing settings, applied only in special addressing
  logic special;
  logic [2:0] next_partial_array_refresh_select;
  assign special = cfg[ddr_tpp_pkg::CFG_SPECIAL];

  // reserved partial-array codes fall back to full coverage
  always_comb begin
    case (partial_array_refresh_select)
      ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_TWO: next_partial_array_refresh_select = partial_array_refresh_select;
      ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_ONE: next_partial_array_refresh_select = partial_array_refresh_select;
      ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_HALF: next_partial_array_refresh_select = partial_array_refresh_select;
      ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_QUARTER: next_partial_array_refresh_select = partial_array_refresh_select;
      default: next_partial_array_refresh_select = ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_FOUR;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_row_bits <= ddr_tpp_pkg::ROW_BITS_BASE;
      o_partial_array_refresh_select_code <= ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_FOUR;
    end else if (special) begin
      o_row_bits <= ddr_tpp_pkg::ROW_BITS_BASE + {2'b00, rowsize};
      o_partial_array_refresh_select_code <= next_partial_array_refresh_select;
    end else begin
      o_row_bits <= ddr_tpp_pkg::ROW_BITS_BASE;
      o_partial_array_refresh_select_code <= ddr_tpp_pkg::PARTIAL_ARRAY_REFRESH_SELECT_FOUR;
    end
  end

  // ==========================================================
  // memory clock sampling and edge detect
  logic mclk_s1;
  logic mclk_s2;
  logic mclk_s3;
  logic mtick;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
    end else begin
      mclk_s1 <= i_mem_clk;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
    end
  end
  assign mtick = mclk_s2 && !mclk_s3;

  // ==========================================================
  // memory-cycle wait timers
  function automatic logic [8:0] tmr(input logic ld, input logic [8:0] v,
                                     input logic [8:0] c, input logic t);
    if (ld) begin
      tmr = v;
    end else if (t && (c != 9'h000)) begin
      tmr = c - 9'h001;
    end else begin
      tmr = c;
    end
  endfunction

  logic [8:0] nr_cnt;
  logic [8:0] rd_cnt;
  logic [8:0] rtp_cnt;
  logic [8:0] cke_cnt;
  logic [8:0] nr_load;
  logic [8:0] next_nr;
  logic [8:0] next_rd;
  logic [8:0] next_rtp;
  logic [8:0] next_cke;

  // load value is field plus one memory cycles
  always_comb begin
    if (i_sr_exit) begin
      nr_load = {2'b00, t_xsnr} + 9'h001;
    end else begin
      nr_load = {7'h00, t_xp} + 9'h001;
    end
  end
  assign next_nr = tmr(i_pd_exit || i_sr_exit, nr_load, nr_cnt, mtick);
  assign next_rd = tmr(i_sr_exit, {1'b0, t_xsrd} + 9'h001, rd_cnt, mtick);
  assign next_rtp = tmr(i_rd_cmd, {6'h00, t_rtp} + 9'h001, rtp_cnt, mtick);
  assign next_cke = tmr(i_cke_toggle, {4'h0, t_cke} + 9'h001, cke_cnt, mtick);

  // timers and the permissions they gate
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      nr_cnt <= 9'h000;
      rd_cnt <= 9'h000;
      rtp_cnt <= 9'h000;
      cke_cnt <= 9'h000;
      o_nonread_ok <= 1'b1;
      o_read_ok <= 1'b1;
      o_pre_ok <= 1'b1;
      o_cke_ok <= 1'b1;
    end else begin
      nr_cnt <= next_nr;
      rd_cnt <= next_rd;
      rtp_cnt <= next_rtp;
      cke_cnt <= next_cke;
      o_nonread_ok <= (next_nr == 9'h000);
      o_read_ok <= (next_rd == 9'h000);
      o_pre_ok <= (next_rtp == 9'h000);
      o_cke_ok <= (next_cke == 9'h000);
    end
  end

  // ==========================================================
  // maximum row open time in refresh intervals
  logic row_open;
  logic [4:0] ras_cnt;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      row_open <= 1'b0;
      ras_cnt <= 5'h00;
      o_row_close_req <= 1'b0;
    end else if (i_pre_cmd) begin
      row_open <= 1'b0;
      ras_cnt <= 5'h00;
      o_row_close_req <= 1'b0;
    end else if (i_act_cmd) begin
      row_open <= 1'b1;
      ras_cnt <= 5'h00;
      o_row_close_req <= 1'b0;
    end else if (row_open && i_refresh_tick && !o_row_close_req) begin
      ras_cnt <= ras_cnt + 5'h01;
      if (ras_cnt == {1'b0, rasmax}) begin // limit is rasmax plus one
        o_row_close_req <= 1'b1;
      end
    end
  end

  // ==========================================================
  // oldest-command priority raise
  logic [8:0] xfer_cnt;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      xfer_cnt <= 9'h000;
      o_raise_oldest <= 1'b0;
    end else if (i_xfer) begin
      // at or past the count, so lowering the count never stalls the raise
      if (xfer_cnt >= {1'b0, prio}) begin // N means N+1 transfers
        xfer_cnt <= 9'h000;
        o_raise_oldest <= 1'b1;
      end else begin
        xfer_cnt <= xfer_cnt + 9'h001;
        o_raise_oldest <= 1'b0;
      end
    end else begin
      o_raise_oldest <= 1'b0;
    end
  end

  // open rows first unless count is zero
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_open_row_first <= 1'b1;
    end else begin
      o_open_row_first <= (prio != 8'h00);
    end
  end

  // ==========================================================
  // performance counters, cleared only by reset
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pc
      logic [3:0] code;
      logic inc;
      assign code = filt[gi * ddr_tpp_pkg::FILT2_LO +: 4];
      // event selection by filter code
      always_comb begin
        case (code)
          ddr_tpp_pkg::FC_RDWR: inc = i_rd_rx || i_wr_rx;
          ddr_tpp_pkg::FC_ACT: inc = i_act_cmd;
          ddr_tpp_pkg::FC_RD: inc = i_rd_rx;
          ddr_tpp_pkg::FC_WR: inc = i_wr_rx;
          ddr_tpp_pkg::FC_FULL: inc = mtick && i_fifo_full;
          ddr_tpp_pkg::FC_RAISE: inc = o_raise_oldest;
          ddr_tpp_pkg::FC_PEND: inc = mtick && i_fifo_nonempty;
          default: inc = 1'b0;
        endcase
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          pc[gi] <= 32'h00000000;
        end else if (inc) begin
          pc[gi] <= pc[gi] + 32'h00000001; // wraps
        end
      end
    end
  endgenerate

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        ddr_tpp_pkg::OFF_CFG: o_rdata <= cfg;
        ddr_tpp_pkg::OFF_TIM2: o_rdata <= {1'b0, tim2};
        ddr_tpp_pkg::OFF_CFG2: o_rdata <= {13'h0000, partial_array_refresh_select, 13'h0000, rowsize};
        ddr_tpp_pkg::OFF_PRIO: o_rdata <= {24'h000000, prio};
        ddr_tpp_pkg::OFF_PC1: o_rdata <= pc[0];
        ddr_tpp_pkg::OFF_PC2: o_rdata <= pc[1];
        ddr_tpp_pkg::OFF_FILT: o_rdata <= filt;
        ddr_tpp_pkg::OFF_STAT: o_rdata <= {27'h0000000, o_row_close_req,
                                           o_cke_ok, o_pre_ok, o_read_ok, o_nonread_ok};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // checks
  property p_lock;
    @(posedge i_clk_sys) disable iff (i_srst)
    (wr_tim2 && !unlock) |=> (tim2 == $past(tim2));
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked timing write changed register");

  property p_init;
    @(posedge i_clk_sys) disable iff (i_srst)
    wr_cfg2 |=> o_init_start;
  endproperty
  a_init: assert property (p_init)
    else $error("no init start after config write");

  property p_pd;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_pd_exit && !i_sr_exit) |=> !o_nonread_ok;
  endproperty
  a_pd: assert property (p_pd)
    else $error("non-read allowed right after power-down exit");

  property p_sr;
    @(posedge i_clk_sys) disable iff (i_srst)
    i_sr_exit |=> (!o_read_ok && (rd_cnt == {1'b0, $past(t_xsrd)} + 9'h001));
  endproperty
  a_sr: assert property (p_sr)
    else $error("read wait not loaded after self-refresh exit");

  property p_rtp;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_rd_cmd && !mtick) |=> !o_pre_ok ##0 (rtp_cnt == {6'h00, $past(t_rtp)} + 9'h001);
  endproperty
  a_rtp: assert property (p_rtp)
    else $error("precharge wait wrong after read");

  property p_cke;
    @(posedge i_clk_sys) disable iff (i_srst)
    i_cke_toggle |=> !o_cke_ok [*2];
  endproperty
  a_cke: assert property (p_cke)
    else $error("clock-enable spacing too short");

  property p_strict;
    @(posedge i_clk_sys) disable iff (i_srst)
    (prio == 8'h00) && ($past(prio) == 8'h00) |-> !o_open_row_first;
  endproperty
  a_strict: assert property (p_strict)
    else $error("open rows favoured with count zero");

  property p_raise0;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_xfer && (prio == 8'h00)) |=> o_raise_oldest;
  endproperty
  a_raise0: assert property (p_raise0)
    else $error("count zero did not raise after one transfer");

  property p_pc_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
    !$past(g_pc[0].inc) |-> (pc[0] == $past(pc[0]));
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("counter changed without event");

endmodule

// ==== ddr_tpp_pkg.sv ====
// constants for the ddr timing, priority and statistics block
package ddr_tpp_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_TIM2 = 8'h04;
  localparam logic [7:0] OFF_CFG2 = 8'h08;
  localparam logic [7:0] OFF_PRIO = 8'h0c;
  localparam logic [7:0] OFF_PC1 = 8'h10;
  localparam logic [7:0] OFF_PC2 = 8'h14;
  localparam logic [7:0] OFF_FILT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  // ==========================================================
  // main configuration bits
  localparam int CFG_UNLOCK = 15;
  localparam int CFG_SPECIAL = 5;
  // ==========================================================
  // second timing register fields
  localparam int T2_RASMAX_LO = 27;
  localparam int T2_XP_LO = 25;
  localparam int T2_ODT_LO = 23;
  localparam int T2_XSNR_LO = 16;
  localparam int T2_XSRD_LO = 8;
  localparam int T2_RTP_LO = 5;
  localparam int T2_CKE_LO = 0;
  localparam logic [30:0] T2_RESET = 31'h4532a722;
  // ==========================================================
  // second configuration fields
  localparam int C2_PARTIAL_ARRAY_REFRESH_SELECT_LO = 16;
  localparam int C2_ROW_LO = 0;
  localparam logic [4:0] ROW_BITS_BASE = 5'h09;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_FOUR = 3'h0;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_TWO = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_ONE = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_HALF = 3'h5;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_QUARTER = 3'h6;
  // ==========================================================
  // priority raise and counter filter
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam int FILT2_LO = 16;
  localparam logic [31:0] FILT_RESET = 32'h00010000;
  localparam logic [3:0] FC_RDWR = 4'h0;
  localparam logic [3:0] FC_ACT = 4'h1;
  localparam logic [3:0] FC_RD = 4'h2;
  localparam logic [3:0] FC_WR = 4'h3;
  localparam logic [3:0] FC_FULL = 4'h4;
  localparam logic [3:0] FC_RAISE = 4'h8;
  localparam logic [3:0] FC_PEND = 4'h9;
endpackage

// ==== mem_side_model.sv ====
// memory side model: clock of the external memory device
`timescale 1ns/100ps
module mem_side_model #(
  parameter real HALF_NS = 40.0
) (
  // memory clock
  output logic o_mem_clk
);
  // ==========================================
  // free running clock, phase unrelated to the system clock
  initial begin
    o_mem_clk = 1'b0;
    #3.7;
    forever #(HALF_NS) o_mem_clk = ~o_mem_clk;
  end
endmodule

// ==== ddr_timing_priority_perfcount_tb_top.sv ====
// self-checking bench for the timing, priority and statistics block
`timescale 1ns/100ps
module ddr_timing_priority_perfcount_tb_top;
  // ==========================================
  // design signals
  logic i_clk_sys, i_srst, i_wr, i_rd, i_mem_clk, i_fifo_nonempty;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [10:0] ev;
  logic o_nonread_ok, o_read_ok, o_pre_ok, o_cke_ok, o_row_close_req;
  logic o_raise_oldest, o_open_row_first, o_init_start;
  logic [4:0] o_row_bits;
  logic [2:0] o_partial_array_refresh_select_code;
  // ==========================================
  // bench state and reference model
  localparam logic [31:0] T2_VAL = 32'h0b820344;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rnd = 32'h59dd;
  logic [31:0] mdl [32];
  logic [31:0] d;
  int n_ev;

  mem_side_model i_mem (.o_mem_clk(i_mem_clk));

  ddr_timing_priority_perfcount i_dut (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_clk(i_mem_clk),
    .i_pd_exit(ev[0]), .i_sr_exit(ev[1]), .i_rd_cmd(ev[2]), .i_act_cmd(ev[3]),
    .i_pre_cmd(ev[4]), .i_cke_toggle(ev[5]), .i_refresh_tick(ev[6]), .i_xfer(ev[7]),
    .i_rd_rx(ev[9]), .i_wr_rx(ev[8]), .i_fifo_full(ev[10]), .i_fifo_nonempty(i_fifo_nonempty),
    .o_nonread_ok(o_nonread_ok), .o_read_ok(o_read_ok), .o_pre_ok(o_pre_ok),
    .o_cke_ok(o_cke_ok), .o_row_close_req(o_row_close_req), .o_raise_oldest(o_raise_oldest),
    .o_open_row_first(o_open_row_first), .o_init_start(o_init_start),
    .o_row_bits(o_row_bits), .o_partial_array_refresh_select_code(o_partial_array_refresh_select_code));

  // system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // writable bits of each stored register
  function automatic logic [31:0] mask(input logic [7:0] a);
    case (a)
      ddr_tpp_pkg::OFF_TIM2: mask = 32'h7fffffff;
      ddr_tpp_pkg::OFF_CFG2: mask = 32'h00070007;
      ddr_tpp_pkg::OFF_PRIO: mask = 32'h000000ff;
      default: mask = 32'hffffffff;
    endcase
  endfunction

  // offsets that hold software state
  function automatic logic stored(input logic [7:0] a);
    stored = a inside {ddr_tpp_pkg::OFF_CFG, ddr_tpp_pkg::OFF_TIM2, ddr_tpp_pkg::OFF_CFG2,
                       ddr_tpp_pkg::OFF_PRIO, ddr_tpp_pkg::OFF_FILT};
  endfunction

  function automatic logic flag(input int f);
    case (f)
      0: flag = o_nonread_ok;
      1: flag = o_read_ok;
      2: flag = o_pre_ok;
      default: flag = o_cke_ok;
    endcase
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // register write, model follows the unlock gate
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    if (stored(a) && (a != ddr_tpp_pkg::OFF_TIM2 || mdl[8'h00][15])) begin
      mdl[a] = v & mask(a);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // one-cycle pulse on an event input
  task automatic pulse(input int k);
    @(posedge i_clk_sys);
    ev[k] <= 1'b1;
    @(posedge i_clk_sys);
    ev <= '0;
    #1;
  endtask

  // event drops the flag, which returns after n+1 memory ticks of 8 cycles
  task automatic timer_chk(input int k, input int f, input int n);
    int c;
    c = 0;
    pulse(k);
    chk({31'h0, flag(f)}, 32'h0);
    while (flag(f) !== 1'b1 && c < 3000) begin
      @(posedge i_clk_sys);
      #1;
      c++;
    end
    chk_rng(c, 8 * n + 1, 8 * n + 10);
    if (c >= 3000) begin
      results();
    end
  endtask

  task automatic do_reset();
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    mdl[ddr_tpp_pkg::OFF_CFG] = 32'h0;
    mdl[ddr_tpp_pkg::OFF_TIM2] = {1'b0, ddr_tpp_pkg::T2_RESET};
    mdl[ddr_tpp_pkg::OFF_CFG2] = 32'h0;
    mdl[ddr_tpp_pkg::OFF_PRIO] = {24'h0, ddr_tpp_pkg::PRIO_RESET};
    mdl[ddr_tpp_pkg::OFF_FILT] = ddr_tpp_pkg::FILT_RESET;
  endtask

  // ==========================================
  // main sequence
  initial begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    ev = '0;
    i_fifo_nonempty = 1'b0;
    do_reset();
    for (int o = 0; o < 32; o += 4) begin
      if (stored(8'(o))) begin
        rd_chk(8'(o), mdl[o]);
      end
    end
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'h0);
    rd_chk(ddr_tpp_pkg::OFF_PC2, 32'h0);
    rd_chk(8'h40, 32'h0);
    rnd = lfsr(rnd);
    wr(ddr_tpp_pkg::OFF_FILT, rnd);
    rd_chk(ddr_tpp_pkg::OFF_FILT, mdl[ddr_tpp_pkg::OFF_FILT]);
    $display("test reset values done");
    wr(ddr_tpp_pkg::OFF_TIM2, T2_VAL);
    rd_chk(ddr_tpp_pkg::OFF_TIM2, mdl[ddr_tpp_pkg::OFF_TIM2]);
    wr(ddr_tpp_pkg::OFF_CFG, 32'h00008000);
    wr(ddr_tpp_pkg::OFF_TIM2, T2_VAL);
    rd_chk(ddr_tpp_pkg::OFF_TIM2, T2_VAL);
    $display("test timing unlock done");
    timer_chk(2, 2, 2);
    timer_chk(5, 3, 4);
    timer_chk(0, 0, 1);
    timer_chk(1, 0, 2);
    timer_chk(1, 1, 3);
    $display("test command spacing done");
    pulse(3);
    pulse(6);
    chk({31'h0, o_row_close_req}, 32'h0);
    pulse(6);
    chk({31'h0, o_row_close_req}, 32'h1);
    pulse(4);
    chk({31'h0, o_row_close_req}, 32'h0);
    $display("test row open limit done");
    wr(ddr_tpp_pkg::OFF_PRIO, 32'h2);
    for (int k = 1; k <= 3; k++) begin
      pulse(7);
      chk({31'h0, o_raise_oldest}, (k == 3) ? 32'h1 : 32'h0);
    end
    chk({31'h0, o_open_row_first}, 32'h1);
    wr(ddr_tpp_pkg::OFF_PRIO, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({31'h0, o_open_row_first}, 32'h0);
    pulse(7);
    chk({31'h0, o_raise_oldest}, 32'h1);
    // recommended count, then a lower count below the running total
    wr(ddr_tpp_pkg::OFF_PRIO, 32'h10);
    for (int k = 1; k <= 23; k++) begin
      if (k == 23) begin
        wr(ddr_tpp_pkg::OFF_PRIO, 32'h2);
      end
      pulse(7);
      chk({31'h0, o_raise_oldest}, (k == 17 || k == 23) ? 32'h1 : 32'h0);
    end
    $display("test priority raise done");
    wr(ddr_tpp_pkg::OFF_CFG2, 32'h00050005);
    #1;
    chk({31'h0, o_init_start}, 32'h1);
    @(posedge i_clk_sys);
    #1;
    chk({27'h0, o_row_bits}, 32'h9);
    chk({29'h0, o_partial_array_refresh_select_code}, 32'h0);
    wr(ddr_tpp_pkg::OFF_CFG, 32'h00008020);
    for (int n = 0; n < 8; n++) begin
      wr(ddr_tpp_pkg::OFF_CFG2, (n << 16) | n);
      #1;
      chk({31'h0, o_init_start}, 32'h1);
      @(posedge i_clk_sys);
      #1;
      chk({27'h0, o_row_bits}, 32'(9 + n));
      chk({29'h0, o_partial_array_refresh_select_code}, (n inside {0, 1, 2, 5, 6}) ? 32'(n) : 32'h0);
      rd_chk(ddr_tpp_pkg::OFF_CFG2, mdl[ddr_tpp_pkg::OFF_CFG2]);
    end
    $display("test addressing setup done");
    wr(ddr_tpp_pkg::OFF_FILT, 32'h00090003);
    rnd = lfsr(rnd);
    n_ev = int'(rnd[2:0]) + 1;
    repeat (n_ev) pulse(8);
    @(posedge i_clk_sys);
    i_fifo_nonempty <= 1'b1;
    repeat (80) @(posedge i_clk_sys);
    i_fifo_nonempty <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    wr(ddr_tpp_pkg::OFF_PC1, 32'h0);
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'(n_ev));
    rd(ddr_tpp_pkg::OFF_PC2, d);
    chk_rng(int'(d), 9, 11);
    @(posedge i_clk_sys);
    do_reset();
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'h0);
    rd_chk(ddr_tpp_pkg::OFF_PC2, 32'h0);
    $display("test counters done");
    // read bursts and raise pulses
    wr(ddr_tpp_pkg::OFF_PRIO, 32'h0);
    wr(ddr_tpp_pkg::OFF_FILT, 32'h00080002);
    repeat (2) pulse(9);
    repeat (3) pulse(7);
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'h2);
    rd_chk(ddr_tpp_pkg::OFF_PC2, 32'h3);
    // activates and fifo-full memory cycles
    wr(ddr_tpp_pkg::OFF_FILT, 32'h00040001);
    pulse(3);
    @(posedge i_clk_sys);
    ev[10] <= 1'b1;
    repeat (80) @(posedge i_clk_sys);
    ev[10] <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'h3);
    rd(ddr_tpp_pkg::OFF_PC2, d);
    chk_rng(int'(d), 12, 14);
    // reads and writes together
    wr(ddr_tpp_pkg::OFF_FILT, 32'h0);
    pulse(8);
    pulse(9);
    rd_chk(ddr_tpp_pkg::OFF_PC1, 32'h5);
    rd_chk(ddr_tpp_pkg::OFF_PC2, d + 32'h2);
    $display("test counter events done");
    results();
  end
endmodule
